/* File: verilog/bfw_pkg.sv */
// package: register map, field layout and types of the forwarding window registers
//
// Behaviour
// - base and limit low nibble read 0001
// - base bits 15:4 give address 31:20
// - limit bits give 31:20, low twenty ones
// - upper bottom word, read-write, reset zero
// - upper top word, read-write, reset zero
// - forward memory inside combined 64-bit window
// - io bottom upper half, read-write, reset zero
// - io top upper half; full 32-bit compare
// - capability pointer reads constant b0
// - io top bits 11:0 ones, 15:12 supplied
package bfw_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0]  BFW_OFS_PREF_WINDOW   = 8'h24;
  localparam logic [7:0]  BFW_OFS_PREF_BOTTOM_HI = 8'h28;
  localparam logic [7:0]  BFW_OFS_PREF_TOP_HI   = 8'h2c;
  localparam logic [7:0]  BFW_OFS_IO_HIGH       = 8'h30;
  localparam logic [7:0]  BFW_OFS_CAP_POINTER   = 8'h34;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BFW_POS_PF_BASE_CODE  = 0;
  localparam int BFW_POS_PF_BASE       = 4;
  localparam int BFW_POS_PF_LIMIT_CODE = 16;
  localparam int BFW_POS_PF_LIMIT      = 20;
  localparam int BFW_POS_IO_BASE_HI    = 0;
  localparam int BFW_POS_IO_LIMIT_HI   = 16;

  // ----------------------------------------------------------------
  // fixed and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0]  BFW_CAP_CODE_64     = 4'h1;
  localparam logic [3:0]  BFW_CAP_CODE_32     = 4'h0;
  localparam logic [7:0]  BFW_CAP_LIST_PTR    = 8'hb0;
  localparam logic [11:0] BFW_RST_PF_FIELD    = 12'h000;
  localparam logic [31:0] BFW_RST_HIGH_WORD   = 32'h0000_0000;
  localparam logic [15:0] BFW_RST_IO_HALF     = 16'h0000;
  localparam logic [3:0]  BFW_RST_IO_LOW      = 4'h0;
  localparam logic [19:0] BFW_PF_BOTTOM_FILL  = 20'h00000;
  localparam logic [19:0] BFW_PF_TOP_FILL     = 20'hfffff;
  localparam logic [11:0] BFW_IO_BOTTOM_FILL  = 12'h000;
  localparam logic [11:0] BFW_IO_TOP_FILL     = 12'hfff;
  localparam logic [31:0] BFW_RDATA_IDLE      = 32'h0000_0000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [11:0] pf_base;
    logic [11:0] pf_limit;
    logic [31:0] pf_base_hi;
    logic [31:0] pf_limit_hi;
    logic [15:0] io_base_hi;
    logic [15:0] io_limit_hi;
  } bfw_fields_t;

  typedef struct packed {
    logic [63:0] pf_bottom;
    logic [63:0] pf_top;
    logic [31:0] io_bottom;
    logic [31:0] io_top;
  } bfw_window_t;

endpackage

/* File: verilog/bfw_regs.sv */
// module: forwarding window register bank with window compare
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps

module bfw_regs
  import bfw_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  input  wire logic [3:0]  i_io_base_low,
  input  wire logic [3:0]  i_io_limit_low,
  input  wire logic        i_mem_valid,
  input  wire logic [63:0] i_mem_addr,
  input  wire logic        i_io_valid,
  input  wire logic [31:0] i_io_addr,
  output logic             o_mem_fwd,
  output logic             o_io_fwd,
  output logic      [63:0] o_pref_bottom,
  output logic      [63:0] o_pref_top,
  output logic      [31:0] o_io_bottom,
  output logic      [31:0] o_io_top
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  bfw_fields_t fld_reg;
  bfw_fields_t fld_next;
  bfw_window_t win_reg;
  bfw_window_t win_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        mem_fwd_reg;
  logic        mem_fwd_next;
  logic        io_fwd_reg;
  logic        io_fwd_next;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic hit_pref;
  logic hit_bottom_hi;
  logic hit_top_hi;
  logic hit_io;
  logic hit_cap;

  assign hit_pref      = (i_addr == BFW_OFS_PREF_WINDOW);
  assign hit_bottom_hi = (i_addr == BFW_OFS_PREF_BOTTOM_HI);
  assign hit_top_hi    = (i_addr == BFW_OFS_PREF_TOP_HI);
  assign hit_io        = (i_addr == BFW_OFS_IO_HIGH);
  assign hit_cap       = (i_addr == BFW_OFS_CAP_POINTER);

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // full-word writes only; the bus carries no byte enables
  always_comb begin
    fld_next = fld_reg;
    if (i_wr) begin
      if (hit_pref) begin
        // code nibbles are not stored, so written data there is dropped
        fld_next.pf_base  = i_wdata[BFW_POS_PF_BASE +: 12];
        fld_next.pf_limit = i_wdata[BFW_POS_PF_LIMIT +: 12];
      end
      if (hit_bottom_hi) begin
        fld_next.pf_base_hi = i_wdata;
      end
      if (hit_top_hi) begin
        fld_next.pf_limit_hi = i_wdata;
      end
      if (hit_io) begin
        fld_next.io_base_hi  = i_wdata[BFW_POS_IO_BASE_HI +: 16];
        fld_next.io_limit_hi = i_wdata[BFW_POS_IO_LIMIT_HI +: 16];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      fld_reg.pf_base     <= BFW_RST_PF_FIELD;
      fld_reg.pf_limit    <= BFW_RST_PF_FIELD;
      fld_reg.pf_base_hi  <= BFW_RST_HIGH_WORD;
      fld_reg.pf_limit_hi <= BFW_RST_HIGH_WORD;
      fld_reg.io_base_hi  <= BFW_RST_IO_HALF;
      fld_reg.io_limit_hi <= BFW_RST_IO_HALF;
    end else begin
      fld_reg <= fld_next;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // unmapped offsets and idle cycles read zero
  always_comb begin
    rdata_next = BFW_RDATA_IDLE;
    if (i_rd) begin
      if (hit_pref) begin
        rdata_next[BFW_POS_PF_BASE_CODE +: 4]  = BFW_CAP_CODE_64;
        rdata_next[BFW_POS_PF_BASE +: 12]      = fld_reg.pf_base;
        rdata_next[BFW_POS_PF_LIMIT_CODE +: 4] = BFW_CAP_CODE_64;
        rdata_next[BFW_POS_PF_LIMIT +: 12]     = fld_reg.pf_limit;
      end
      if (hit_bottom_hi) begin
        rdata_next = fld_reg.pf_base_hi;
      end
      if (hit_top_hi) begin
        rdata_next = fld_reg.pf_limit_hi;
      end
      if (hit_io) begin
        rdata_next[BFW_POS_IO_BASE_HI +: 16]  = fld_reg.io_base_hi;
        rdata_next[BFW_POS_IO_LIMIT_HI +: 16] = fld_reg.io_limit_hi;
      end
      if (hit_cap) begin
        rdata_next[7:0] = BFW_CAP_LIST_PTR;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_reg <= BFW_RDATA_IDLE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // window bounds
  // ----------------------------------------------------------------
  // built from the next field values so bounds track writes with no lag
  always_comb begin
    win_next.pf_bottom = {fld_next.pf_base_hi, fld_next.pf_base, BFW_PF_BOTTOM_FILL};
    win_next.pf_top    = {fld_next.pf_limit_hi, fld_next.pf_limit, BFW_PF_TOP_FILL};
    win_next.io_bottom = {fld_next.io_base_hi, i_io_base_low, BFW_IO_BOTTOM_FILL};
    win_next.io_top    = {fld_next.io_limit_hi, i_io_limit_low, BFW_IO_TOP_FILL};
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      win_reg.pf_bottom <= {BFW_RST_HIGH_WORD, BFW_RST_PF_FIELD, BFW_PF_BOTTOM_FILL};
      win_reg.pf_top    <= {BFW_RST_HIGH_WORD, BFW_RST_PF_FIELD, BFW_PF_TOP_FILL};
      win_reg.io_bottom <= {BFW_RST_IO_HALF, BFW_RST_IO_LOW, BFW_IO_BOTTOM_FILL};
      win_reg.io_top    <= {BFW_RST_IO_HALF, BFW_RST_IO_LOW, BFW_IO_TOP_FILL};
    end else begin
      win_reg <= win_next;
    end
  end

  // ----------------------------------------------------------------
  // forwarding decision
  // ----------------------------------------------------------------
  // bottom above top gives an empty window, nothing is forwarded
  always_comb begin
    mem_fwd_next = i_mem_valid
                   && (i_mem_addr >= win_reg.pf_bottom)
                   && (i_mem_addr <= win_reg.pf_top);
    io_fwd_next  = i_io_valid
                   && (i_io_addr >= win_reg.io_bottom)
                   && (i_io_addr <= win_reg.io_top);
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mem_fwd_reg <= 1'b0;
      io_fwd_reg  <= 1'b0;
    end else begin
      mem_fwd_reg <= mem_fwd_next;
      io_fwd_reg  <= io_fwd_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_rdata       = rdata_reg;
  assign o_mem_fwd     = mem_fwd_reg;
  assign o_io_fwd      = io_fwd_reg;
  assign o_pref_bottom = win_reg.pf_bottom;
  assign o_pref_top    = win_reg.pf_top;
  assign o_io_bottom   = win_reg.io_bottom;
  assign o_io_top      = win_reg.io_top;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  chk_cap_code_read: assert property (
    (i_rd && hit_pref) |=> (o_rdata[3:0] == 4'h1) && (o_rdata[19:16] == 4'h1))
    else $error("capability code not 0001 on window read");

  chk_base_write: assert property (
    (i_wr && hit_pref) |=> (o_pref_bottom[31:20] == $past(i_wdata[15:4]))
                           && (o_pref_bottom[19:0] == 20'h00000))
    else $error("prefetch bottom not taken from written base");

  chk_limit_write: assert property (
    (i_wr && hit_pref) |=> (o_pref_top[31:20] == $past(i_wdata[31:20]))
                           && (o_pref_top[19:0] == 20'hfffff))
    else $error("prefetch top not taken from written limit");

  chk_bottom_high: assert property (
    (i_wr && hit_bottom_hi) ##1 (!i_wr)[*2] |-> (o_pref_bottom[63:32] == $past(i_wdata, 2))
    )
    else $error("bottom upper word lost after write");

  chk_top_high_rd: assert property (
    (i_wr && hit_top_hi) ##1 (i_rd && hit_top_hi && !i_wr) |=> (o_rdata == $past(i_wdata, 2)))
    else $error("top upper word reads back wrong");

  chk_mem_forward: assert property (
    !$past(i_rst) |-> o_mem_fwd == $past(i_mem_valid && (i_mem_addr >= o_pref_bottom)
                                         && (i_mem_addr <= o_pref_top)))
    else $error("memory forward decision mismatch");

  chk_io_bottom: assert property (
    (i_wr && hit_io) |=> (o_io_bottom[31:16] == $past(i_wdata[15:0]))
                         && (o_io_bottom[11:0] == 12'h000))
    else $error("io bottom upper half not updated");

  chk_io_forward: assert property (
    !$past(i_rst) |-> o_io_fwd == $past(i_io_valid && (i_io_addr >= o_io_bottom)
                                        && (i_io_addr <= o_io_top)))
    else $error("io forward decision mismatch");

  chk_cap_pointer: assert property (
    (i_rd && hit_cap) |=> (o_rdata == 32'h0000_00b0))
    else $error("capability pointer not b0");

  chk_io_top_low: assert property (
    ##1 (o_io_top[11:0] == 12'hfff) && (o_io_top[15:12] == $past(i_io_limit_low)))
    else $error("io top low bits wrong");

  chk_ro_write: assert property (
    (i_wr && hit_cap) |=> $stable(o_pref_bottom) && $stable(o_pref_top)
                          && $stable(o_io_top[31:16]) && $stable(o_io_bottom[31:16]))
    else $error("write to read-only pointer changed state");

  chk_reset_zero: assert property (
    $past(i_rst) |-> (o_pref_bottom[63:32] == 32'h0) && (o_pref_top[63:32] == 32'h0)
                     && (o_io_bottom[31:16] == 16'h0) && (o_io_top[31:16] == 16'h0))
    else $error("upper bounds not zero after reset");

  chk_rdata_idle: assert property (
    !$past(i_rd) |-> (o_rdata == 32'h0))
    else $error("read data outside the read answer cycle");

  chk_io_top_write: assert property (
    (i_wr && hit_io) |=> (o_io_top[31:16] == $past(i_wdata[31:16]))
                         && (o_io_top[11:0] == 12'hfff))
    else $error("io top upper half not updated");

  chk_top_high: assert property (
    (i_wr && hit_top_hi) |=> (o_pref_top[63:32] == $past(i_wdata)))
    else $error("top upper word not taken from write");

  chk_bottom_high_rd: assert property (
    (i_rd && hit_bottom_hi) |=> (o_rdata == $past(o_pref_bottom[63:32])))
    else $error("bottom upper word reads back wrong");

  chk_window_rd: assert property (
    (i_rd && hit_pref) |=> (o_rdata[15:4] == $past(o_pref_bottom[31:20]))
                           && (o_rdata[31:20] == $past(o_pref_top[31:20])))
    else $error("window register reads back wrong");

  chk_io_rd: assert property (
    (i_rd && hit_io) |=> (o_rdata[15:0] == $past(o_io_bottom[31:16]))
                         && (o_rdata[31:16] == $past(o_io_top[31:16])))
    else $error("io upper halves read back wrong");

  chk_code_ro: assert property (
    (i_wr && hit_pref) ##1 (i_rd && hit_pref && !i_wr)
      |=> (o_rdata[3:0] == 4'h1) && (o_rdata[19:16] == 4'h1))
    else $error("capability code took written data");

  chk_unmapped_rd: assert property (
    (i_rd && !(hit_pref || hit_bottom_hi || hit_top_hi || hit_io || hit_cap))
      |=> (o_rdata == 32'h0))
    else $error("unmapped offset read non-zero");

  chk_hold_no_write: assert property (
    !i_wr |=> $stable(o_pref_bottom) && $stable(o_pref_top)
              && $stable(o_io_bottom[31:16]) && $stable(o_io_top[31:16]))
    else $error("window bound moved with no write");

  chk_fill_bits: assert property (
    (o_pref_bottom[19:0] == 20'h00000) && (o_pref_top[19:0] == 20'hfffff)
    && (o_io_bottom[11:0] == 12'h000) && (o_io_top[11:0] == 12'hfff))
    else $error("fixed low address bits wrong");

  chk_io_bottom_low: assert property (
    ##1 (o_io_bottom[15:12] == $past(i_io_base_low)))
    else $error("io bottom bits 15:12 not taken from input");

  chk_mem_idle: assert property (
    !i_mem_valid |=> !o_mem_fwd)
    else $error("memory forward without a request");

  chk_io_idle: assert property (
    !i_io_valid |=> !o_io_fwd)
    else $error("io forward without a request");

  chk_mem_empty: assert property (
    (o_pref_bottom > o_pref_top) |=> !o_mem_fwd)
    else $error("memory forward through an empty window");

  chk_io_empty: assert property (
    (o_io_bottom > o_io_top) |=> !o_io_fwd)
    else $error("io forward through an empty window");

  chk_mem_bottom_edge: assert property (
    (i_mem_valid && (i_mem_addr == o_pref_bottom) && (o_pref_bottom <= o_pref_top))
      |=> o_mem_fwd)
    else $error("memory request at window bottom not forwarded");

  chk_mem_top_edge: assert property (
    (i_mem_valid && (i_mem_addr == o_pref_top) && (o_pref_bottom <= o_pref_top))
      |=> o_mem_fwd)
    else $error("memory request at window top not forwarded");

  chk_io_bottom_edge: assert property (
    (i_io_valid && (i_io_addr == o_io_bottom) && (o_io_bottom <= o_io_top))
      |=> o_io_fwd)
    else $error("io request at window bottom not forwarded");

  chk_io_top_edge: assert property (
    (i_io_valid && (i_io_addr == o_io_top) && (o_io_bottom <= o_io_top))
      |=> o_io_fwd)
    else $error("io request at window top not forwarded");

  // ----------------------------------------------------------------
  // cover points
  // ----------------------------------------------------------------
  cov_mem_fwd: cover property (i_mem_valid ##1 o_mem_fwd);
  cov_io_fwd: cover property (i_io_valid ##1 o_io_fwd);
  cov_write_read: cover property ((i_wr && hit_pref) ##1 (i_rd && hit_pref));
  cov_high_window: cover property (o_pref_top[63:32] != 32'h0 ##1 o_mem_fwd);
  cov_empty_window: cover property ((o_pref_bottom > o_pref_top) && i_mem_valid);

endmodule

/* File: testbench/bfw_regs_tb_top.sv */
// testbench: random and corner checks of the forwarding window register bank
`timescale 1ns/1ps

module bfw_regs_tb_top;
  import bfw_pkg::*;
  // ----------------------------------------------------------------
  // signals and reference model
  // ----------------------------------------------------------------
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic [7:0]  i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [31:0] o_rdata;
  logic [3:0]  i_io_base_low = 4'h0;
  logic [3:0]  i_io_limit_low = 4'h0;
  logic        i_mem_valid = 1'b0;
  logic [63:0] i_mem_addr = 64'h0;
  logic        i_io_valid = 1'b0;
  logic [31:0] i_io_addr = 32'h0;
  logic        o_mem_fwd;
  logic        o_io_fwd;
  logic [63:0] o_pref_bottom;
  logic [63:0] o_pref_top;
  logic [31:0] o_io_bottom;
  logic [31:0] o_io_top;
  bfw_fields_t m = '0;
  logic [3:0]  m_iob = 4'h0;
  logic [3:0]  m_iol = 4'h0;
  integer      seed = 32'h2363a83d;
  int          failures = 0;
  int          tests_run = 0;
  int          cyc = 0;
  logic [7:0]  ofs [6] = '{8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h38};

  always #10 i_clk = ~i_clk;

  bfw_regs i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_io_base_low(i_io_base_low),
    .i_io_limit_low(i_io_limit_low), .i_mem_valid(i_mem_valid), .i_mem_addr(i_mem_addr),
    .i_io_valid(i_io_valid), .i_io_addr(i_io_addr), .o_mem_fwd(o_mem_fwd),
    .o_io_fwd(o_io_fwd), .o_pref_bottom(o_pref_bottom), .o_pref_top(o_pref_top),
    .o_io_bottom(o_io_bottom), .o_io_top(o_io_top));

  // ----------------------------------------------------------------
  // expectations
  // ----------------------------------------------------------------
  function automatic logic [31:0] exp_read(logic [7:0] a);
    case (a)
      BFW_OFS_PREF_WINDOW:    exp_read = {m.pf_limit, 4'h1, m.pf_base, 4'h1};
      BFW_OFS_PREF_BOTTOM_HI: exp_read = m.pf_base_hi;
      BFW_OFS_PREF_TOP_HI:    exp_read = m.pf_limit_hi;
      BFW_OFS_IO_HIGH:        exp_read = {m.io_limit_hi, m.io_base_hi};
      BFW_OFS_CAP_POINTER:    exp_read = 32'h0000_00b0;
      default:                exp_read = 32'h0;
    endcase
  endfunction

  function automatic bfw_window_t exp_win();
    exp_win.pf_bottom = {m.pf_base_hi, m.pf_base, 20'h00000};
    exp_win.pf_top    = {m.pf_limit_hi, m.pf_limit, 20'hfffff};
    exp_win.io_bottom = {m.io_base_hi, m_iob, 12'h000};
    exp_win.io_top    = {m.io_limit_hi, m_iol, 12'hfff};
  endfunction

  // ----------------------------------------------------------------
  // compare and bus tasks
  // ----------------------------------------------------------------
  task automatic chk_data(logic [63:0] got, logic [63:0] exp, string what);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_flag(logic got, logic exp, string what);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic upd(logic [7:0] a, logic [31:0] d);
    case (a)
      8'h24: begin
        m.pf_base = d[15:4];
        m.pf_limit = d[31:20];
      end
      8'h28: m.pf_base_hi = d;
      8'h2c: m.pf_limit_hi = d;
      8'h30: begin
        m.io_base_hi = d[15:0];
        m.io_limit_hi = d[31:16];
      end
      default: ;
    endcase
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    upd(a, d);
  endtask

  // write then read with no gap, the read must see the new value
  task automatic wr_rd(logic [7:0] a, logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b1;
    upd(a, d);
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk_data({32'h0, o_rdata}, {32'h0, exp_read(a)}, "write then read");
  endtask

  task automatic rd(logic [7:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk_data({32'h0, o_rdata}, {32'h0, exp_read(a)}, "read data");
  endtask

  task automatic chk_win();
    bfw_window_t w;
    w = exp_win();
    chk_data(o_pref_bottom, w.pf_bottom, "pref bottom");
    chk_data(o_pref_top, w.pf_top, "pref top");
    chk_data({32'h0, o_io_bottom}, {32'h0, w.io_bottom}, "io bottom");
    chk_data({32'h0, o_io_top}, {32'h0, w.io_top}, "io top");
  endtask

  task automatic fwd(logic [63:0] ma, logic [31:0] ia, logic mv, logic iv);
    bfw_window_t w;
    w = exp_win();
    @(posedge i_clk);
    i_mem_valid <= mv;
    i_mem_addr <= ma;
    i_io_valid <= iv;
    i_io_addr <= ia;
    @(posedge i_clk);
    i_mem_valid <= 1'b0;
    i_io_valid <= 1'b0;
    #1 chk_flag(o_mem_fwd, mv && ma >= w.pf_bottom && ma <= w.pf_top, "mem fwd");
    chk_flag(o_io_fwd, iv && ia >= w.io_bottom && ia <= w.io_top, "io fwd");
  endtask

  task automatic print_verdict();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // hang guard, generous against roughly 1250 cycles of traffic
  // ----------------------------------------------------------------
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    bfw_window_t w;
    logic [1:0]  pk;
    logic [31:0] rnd;
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    #1 chk_win();
    foreach (ofs[k]) rd(ofs[k]);
    wr(8'h24, 32'hfff0_fff0);
    rd(8'h24);
    wr(8'h34, 32'hffff_ffff);
    rd(8'h34);
    wr_rd(8'h2c, 32'h8000_0001);
    wr_rd(8'h24, 32'h123e_456e);
    for (int n = 0; n < 60; n++) begin
      wr(ofs[$unsigned($random(seed)) % 6], $random(seed));
      rd(ofs[$unsigned($random(seed)) % 6]);
      wr_rd(ofs[$unsigned($random(seed)) % 6], $random(seed));
      @(posedge i_clk);
      rnd = $random(seed);
      i_io_base_low <= rnd[3:0];
      i_io_limit_low <= rnd[7:4];
      m_iob = rnd[3:0];
      m_iol = rnd[7:4];
      repeat (2) @(posedge i_clk);
      #1 chk_win();
      w = exp_win();
      // bound probes: the exact bound addresses catch exclusive compares, the off-by-one ones catch too-wide compares
      for (int k = 0; k < 5; k++) begin
        pk = k[1:0];
        case (k)
          0: fwd(w.pf_bottom, w.io_bottom, 1'b1, 1'b1);
          1: fwd(w.pf_top, w.io_top, 1'b1, 1'b1);
          2: fwd(w.pf_bottom - 64'h1, w.io_bottom - 32'h1, 1'b1, 1'b1);
          3: fwd(w.pf_top + 64'h1, w.io_top + 32'h1, pk[0], 1'b1);
          default: fwd({$random(seed), $random(seed)}, $random(seed), 1'b1, 1'b0);
        endcase
      end
    end
    print_verdict();
  end
endmodule
